// ### asrb_params.svh
// Shared addresses, reset values, field positions and timing counts.
`ifndef ASRB_PARAMS_SVH
`define ASRB_PARAMS_SVH
`define ASRB_ADDR_CFG      13'h000
`define ASRB_ADDR_ID       13'h001
`define ASRB_ADDR_GRADE    13'h002
`define ASRB_ADDR_CHAN     13'h005
`define ASRB_ADDR_GCLK     13'h009
`define ASRB_ADDR_XFER     13'h0ff
`define ASRB_SHADOW_LO     13'h008
`define ASRB_SHADOW_HI     13'h079
`define ASRB_SHADOW_N      114
`define ASRB_SHADOW_LOCAL  114'h1
`define ASRB_GCLK_IDX      7'h01
`define ASRB_CFG_RESET     8'h18
`define ASRB_CHAN_RESET    2'h3
`define ASRB_GCLK_RESET    8'h01
`define ASRB_XFER_CMD      8'h01
`define ASRB_CFG_LSB_HI    6
`define ASRB_CFG_LSB_LO    1
`define ASRB_CFG_SRST_HI   5
`define ASRB_CFG_SRST_LO   2
`define ASRB_GRADE_LSB     4
`define ASRB_INSTR_BITS    5'h10
`define ASRB_FRAME_BITS    5'h18
`define ASRB_HREG_ADDR     8'h00
`define ASRB_HREG_WDATA    8'h04
`define ASRB_HREG_CTRL     8'h08
`define ASRB_HREG_STATUS   8'h0c
`define ASRB_HREG_RDATA    8'h10
`define ASRB_CTRL_WR       0
`define ASRB_CTRL_RD       1
`define ASRB_CTRL_LSB      2
`define ASRB_SCLK_HALF     4'h2
`endif

// ### asrb_pkg.sv
// Types shared by both ends of the serial register link.
`include "asrb_params.svh"
package asrb_pkg;
	typedef enum logic [1:0] {
		DEV_IDLE = 2'b00,
		DEV_BUSY = 2'b01
	} asrb_dev_state_t;

	typedef enum logic [1:0] {
		HST_IDLE = 2'b00,
		HST_LOW  = 2'b01,
		HST_HIGH = 2'b10,
		HST_DONE = 2'b11
	} asrb_hst_state_t;

	typedef logic [0:`ASRB_SHADOW_N-1][7:0] asrb_bank_t;

	typedef struct packed {
		logic [4:0]  cnt;
		logic        sclk;
		logic [15:0] ins;
		logic [7:0]  dat;
		logic [7:0]  rd;
		logic        sdo;
		logic        oe;
		logic        lsb;
		logic [1:0]  chan;
		logic        xfer;
		logic        xpulse;
		asrb_bank_t  sh_a;
		asrb_bank_t  sh_b;
		asrb_bank_t  ac_a;
		asrb_bank_t  ac_b;
		logic [7:0]  out_a;
		logic [7:0]  out_b;
	} asrb_dev_st_t;

	typedef struct packed {
		asrb_hst_state_t st;
		logic [3:0]      div;
		logic [4:0]      bitn;
		logic            sclk;
		logic            csb;
		logic            sdo;
		logic            oe;
		logic            rw;
		logic [12:0]     addr;
		logic [7:0]      wdata;
		logic [7:0]      rdata;
		logic            lsb;
		logic            busy;
		logic            done;
		logic [31:0]     bus_rdata;
	} asrb_hst_st_t;
endpackage : asrb_pkg

// ### asrb_link_if.sv
// Three-wire serial link joining the host end and the device end.
`timescale 1ns/1ns
interface asrb_link_if;
	logic sclk;
	logic csb;
	logic sdio_h_o;
	logic sdio_h_oe;
	logic sdio_d_o;
	logic sdio_d_oe;
	logic sdio;

	// The shared data wire idles high when neither end drives it.
	assign sdio = sdio_d_oe ? sdio_d_o : (sdio_h_oe ? sdio_h_o : 1'b1);

	modport dev (
		input  sclk,
		input  csb,
		input  sdio,
		output sdio_d_o,
		output sdio_d_oe
	);

	modport host (
		output sclk,
		output csb,
		output sdio_h_o,
		output sdio_h_oe,
		input  sdio
	);
endinterface : asrb_link_if

// ### asrb_device.sv
// Device end: serial slave and double-buffered configuration register bank.
//
// Summary of operation
// - Decode chip, index, converter and link groups.
// - Registers are eight bits, bit 7 MSB.
// - Host writes zero into unused bits; asrb_host sends the data bits as software wrote them.
// - Host never writes fully unused addresses; asrb_host sends whatever address software sets.
// - Any reset loads documented default values.
// - Range 0x08-0x79 written to shadow copies.
// - Writing 0x01 to 0xFF commands transfer.
// - Transfer copies all shadows, then bit autoclears.
// - Local registers duplicated, chosen by 0x05.
// - Both select bits write both copies.
// - Host selects one channel before local reads.
// - Both selected on read returns channel A.
// - Global registers ignore channel select bits.
// - Port config mirrored nibbles, default 0x18.
// - Host sets all select bits before config.
// - MSB first until bit order selects LSB.
`timescale 1ns/1ns
`include "asrb_params.svh"
module asrb_device #(
	parameter logic [7:0] DEVICE_IDENTIFIER = 8'h5a,
	parameter logic [1:0] GRADE   = 2'h0
) (
	// Clock and reset.
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// Serial link.
	asrb_link_if.dev         link,
	// Active setting readout.
	input  wire logic [6:0]  act_sel,
	output logic      [7:0]  act_a_q,
	output logic      [7:0]  act_b_q,
	output logic             lsb_first_q,
	output logic             xfer_pulse_q
);
	// DEVICE_IDENTIFIER value is arbitrary and only identifies this model.
	asrb_pkg::asrb_dev_st_t q;
	asrb_pkg::asrb_dev_st_t n;
	// Marks which shadow entries exist once per channel.
	localparam logic [`ASRB_SHADOW_N-1:0] LOCAL_MAP = `ASRB_SHADOW_LOCAL;

	// Builds the state that any reset leaves behind.
	function automatic asrb_pkg::asrb_dev_st_t dflt();
		asrb_pkg::asrb_dev_st_t s;
		s = '0;
		s.chan = `ASRB_CHAN_RESET;
		s.sh_a[`ASRB_GCLK_IDX] = `ASRB_GCLK_RESET;
		s.sh_b[`ASRB_GCLK_IDX] = `ASRB_GCLK_RESET;
		s.ac_a[`ASRB_GCLK_IDX] = `ASRB_GCLK_RESET;
		s.ac_b[`ASRB_GCLK_IDX] = `ASRB_GCLK_RESET;
		return s;
	endfunction : dflt

	function automatic logic in_shadow(input logic [12:0] a);
		return (a >= `ASRB_SHADOW_LO) && (a <= `ASRB_SHADOW_HI);
	endfunction : in_shadow

	// Value returned for a read of address a.
	function automatic logic [7:0] rd_val(
		input asrb_pkg::asrb_dev_st_t s,
		input logic [12:0]            a
	);
		logic [6:0] i;
		logic [7:0] v;
		i = 7'(a - `ASRB_SHADOW_LO);
		v = 8'h00;
		case (a)
			`ASRB_ADDR_CFG:
			begin
				v = `ASRB_CFG_RESET;
				v[`ASRB_CFG_LSB_HI] = s.lsb;
				v[`ASRB_CFG_LSB_LO] = s.lsb;
			end
			`ASRB_ADDR_ID:    v = DEVICE_IDENTIFIER;
			`ASRB_ADDR_GRADE: v[`ASRB_GRADE_LSB +: 2] = GRADE;
			`ASRB_ADDR_CHAN:  v[1:0] = s.chan;
			`ASRB_ADDR_XFER:  v[0] = s.xfer;
			default:
			begin
				// Channel A wins when both selected.
				if (in_shadow(a))
					v = s.chan[0] ? s.sh_a[i] : s.sh_b[i];
			end
		endcase
		return v;
	endfunction : rd_val

	logic        rise;
	logic        fall;
	logic [15:0] ins_nx;
	logic [7:0]  dat_nx;
	logic [12:0] waddr;
	logic [6:0]  widx;
	logic [2:0]  didx;
	logic        wr_a;
	logic        wr_b;

	always_comb
	begin
		n = q;
		n.sclk = link.sclk;
		n.xpulse = 1'b0;
		rise = link.sclk & ~q.sclk;
		fall = ~link.sclk & q.sclk;
		// Bit order follows the configured mode.
		ins_nx = q.lsb ? {link.sdio, q.ins[15:1]} : {q.ins[14:0], link.sdio};
		// Data bytes are eight bits wide.
		dat_nx = q.lsb ? {link.sdio, q.dat[7:1]} : {q.dat[6:0], link.sdio};
		waddr = q.ins[12:0];
		widx = 7'(waddr - `ASRB_SHADOW_LO);
		didx = 3'(q.cnt - `ASRB_INSTR_BITS);
		// Global entries keep both copies equal.
		wr_a = q.chan[0] || !LOCAL_MAP[widx];
		wr_b = q.chan[1] || !LOCAL_MAP[widx];

		// Copy all shadows at once, then autoclear.
		if (q.xfer)
		begin
			n.ac_a = q.sh_a;
			n.ac_b = q.sh_b;
			n.xfer = 1'b0;
			n.xpulse = 1'b1;
		end

		if (link.csb)
		begin
			n.cnt = 5'h00;
			n.oe = 1'b0;
		end
		else
		begin
			if (rise && q.cnt < `ASRB_FRAME_BITS)
			begin
				n.cnt = q.cnt + 5'h01;
				if (q.cnt < `ASRB_INSTR_BITS)
					n.ins = ins_nx;
				else
					n.dat = dat_nx;
				if (q.cnt == `ASRB_INSTR_BITS - 5'h01)
					n.rd = rd_val(q, ins_nx[12:0]);
			end
			if (fall)
			begin
				n.oe = q.ins[15] && q.cnt >= `ASRB_INSTR_BITS &&
					q.cnt < `ASRB_FRAME_BITS;
				n.sdo = q.lsb ? q.rd[didx] : q.rd[3'h7 - didx];
			end
			// Write lands when its last bit is taken.
			if (rise && !q.ins[15] &&
				q.cnt == `ASRB_FRAME_BITS - 5'h01)
			begin
				case (waddr)
					`ASRB_ADDR_CFG:
					begin
						// Either mirrored copy sets the field.
						n.lsb = dat_nx[`ASRB_CFG_LSB_HI] |
							dat_nx[`ASRB_CFG_LSB_LO];
						if (dat_nx[`ASRB_CFG_SRST_HI] |
							dat_nx[`ASRB_CFG_SRST_LO])
						begin
							n = dflt();
							n.sclk = link.sclk;
							n.cnt = `ASRB_FRAME_BITS;
						end
					end
					`ASRB_ADDR_CHAN: n.chan = dat_nx[1:0];
					`ASRB_ADDR_XFER:
						n.xfer = dat_nx == `ASRB_XFER_CMD;
					default:
					begin
						if (in_shadow(waddr))
						begin
							if (wr_a)
								n.sh_a[widx] = dat_nx;
							if (wr_b)
								n.sh_b[widx] = dat_nx;
						end
					end
				endcase
			end
		end

		n.out_a = (act_sel < 7'(`ASRB_SHADOW_N)) ? q.ac_a[act_sel] : 8'h00;
		n.out_b = (act_sel < 7'(`ASRB_SHADOW_N)) ? q.ac_b[act_sel] : 8'h00;

		if (reset)
			n = dflt();
	end

	always_ff @(posedge clk_sys)
	begin
		q <= n;
	end

	assign link.sdio_d_o = q.sdo;
	assign link.sdio_d_oe = q.oe;
	assign act_a_q = q.out_a;
	assign act_b_q = q.out_b;
	assign lsb_first_q = q.lsb;
	assign xfer_pulse_q = q.xpulse;
endmodule : asrb_device

// ### asrb_host.sv
// Host end: register-commanded serial master for the register bank.
`timescale 1ns/1ns
`include "asrb_params.svh"
module asrb_host #(
	parameter logic [3:0] SCLK_HALF = `ASRB_SCLK_HALF
) (
	// Clock and reset.
	input  wire logic        clk_sys,
	input  wire logic        reset,
	// Software register port.
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	// Serial link.
	asrb_link_if.host        link
);
	asrb_pkg::asrb_hst_st_t q;
	asrb_pkg::asrb_hst_st_t n;

	// Line level for frame bit i, instruction first then data.
	function automatic logic bit_val(
		input asrb_pkg::asrb_hst_st_t s,
		input logic [4:0]             i
	);
		logic [15:0] ins;
		logic [2:0]  j;
		ins = {s.rw, 2'b00, s.addr};
		j = 3'(i - `ASRB_INSTR_BITS);
		// Shift order matches the device mode.
		if (i < `ASRB_INSTR_BITS)
			return s.lsb ? ins[4'(i)] : ins[4'hf - 4'(i)];
		return s.lsb ? s.wdata[j] : s.wdata[3'h7 - j];
	endfunction : bit_val

	logic [4:0] nb;

	always_comb
	begin
		n = q;
		n.bus_rdata = 32'h0;
		nb = q.bitn + 5'h01;
		case (q.st)
			asrb_pkg::HST_IDLE:
			begin
				n.csb = 1'b1;
				n.sclk = 1'b0;
				n.oe = 1'b0;
			end
			asrb_pkg::HST_LOW:
			begin
				n.div = q.div + 4'h1;
				if (q.div == SCLK_HALF - 4'h1)
				begin
					n.div = 4'h0;
					n.sclk = 1'b1;
					n.st = asrb_pkg::HST_HIGH;
				end
			end
			asrb_pkg::HST_HIGH:
			begin
				n.div = q.div + 4'h1;
				if (q.div == SCLK_HALF - 4'h1)
				begin
					n.div = 4'h0;
					n.sclk = 1'b0;
					if (q.rw && q.bitn >= `ASRB_INSTR_BITS)
						n.rdata = q.lsb ? {link.sdio, q.rdata[7:1]} :
							{q.rdata[6:0], link.sdio};
					n.bitn = nb;
					if (nb == `ASRB_FRAME_BITS)
					begin
						n.oe = 1'b0;
						n.st = asrb_pkg::HST_DONE;
					end
					else
					begin
						n.sdo = bit_val(q, nb);
						n.oe = !(q.rw && nb >= `ASRB_INSTR_BITS);
						n.st = asrb_pkg::HST_LOW;
					end
				end
			end
			asrb_pkg::HST_DONE:
			begin
				n.csb = 1'b1;
				n.busy = 1'b0;
				n.st = asrb_pkg::HST_IDLE;
			end
			default: n.st = asrb_pkg::HST_IDLE;
		endcase

		if (reg_rd)
		begin
			case (reg_addr)
				`ASRB_HREG_ADDR:   n.bus_rdata = 32'(q.addr);
				`ASRB_HREG_WDATA:  n.bus_rdata = 32'(q.wdata);
				`ASRB_HREG_CTRL:   n.bus_rdata = 32'({q.lsb, 2'b00});
				`ASRB_HREG_STATUS: n.bus_rdata = 32'({q.done, q.busy});
				`ASRB_HREG_RDATA:  n.bus_rdata = 32'(q.rdata);
				default:           n.bus_rdata = 32'h0;
			endcase
			if (reg_addr == `ASRB_HREG_STATUS)
				n.done = 1'b0;
		end
		// A completion in the cycle of a status read stays visible.
		if (q.st == asrb_pkg::HST_DONE)
			n.done = 1'b1;

		if (reg_wr && !q.busy)
		begin
			case (reg_addr)
				// Software must pick a used address.
				`ASRB_HREG_ADDR:  n.addr = reg_wdata[12:0];
				// Unused bits go out as software wrote them.
				`ASRB_HREG_WDATA: n.wdata = reg_wdata[7:0];
				`ASRB_HREG_CTRL:
				begin
					n.lsb = reg_wdata[`ASRB_CTRL_LSB];
					if (reg_wdata[`ASRB_CTRL_WR] || reg_wdata[`ASRB_CTRL_RD])
					begin
						n.rw = reg_wdata[`ASRB_CTRL_RD];
						n.busy = 1'b1;
						n.done = 1'b0;
						n.csb = 1'b0;
						n.bitn = 5'h00;
						n.div = 4'h0;
						n.oe = 1'b1;
						n.sdo = bit_val(n, 5'h00);
						n.st = asrb_pkg::HST_LOW;
					end
				end
				default: n.st = n.st;
			endcase
		end

		if (reset)
		begin
			n = '0;
			n.csb = 1'b1;
			n.st = asrb_pkg::HST_IDLE;
		end
	end

	always_ff @(posedge clk_sys)
	begin
		q <= n;
	end

	assign reg_rdata = q.bus_rdata;
	assign link.sclk = q.sclk;
	assign link.csb = q.csb;
	assign link.sdio_h_o = q.sdo;
	assign link.sdio_h_oe = q.oe;
endmodule : asrb_host

// ### asrb_props.sv
// Checker watching the wires between the host and device ends.
`timescale 1ns/1ns
module asrb_props (
	// Clock and reset.
	input wire logic	clk_sys,
	input wire logic	reset,
	// Serial link wires.
	input wire logic	sclk,
	input wire logic	csb,
	input wire logic	sdio_h_o,
	input wire logic	sdio_h_oe,
	input wire logic	sdio_d_o,
	input wire logic	sdio_d_oe,
	input wire logic	sdio
);
	logic		sclk_q;
	logic [4:0]	rise_q;

	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (reset);

	// Counts rising serial clock edges within the current frame.
	always_ff @(posedge clk_sys)
	begin
		sclk_q <= sclk;
		rise_q <= csb ? 5'h00 : rise_q + {4'h0, sclk & ~sclk_q};
	end

	a_frame_bits: assert property ($rose(csb) |-> rise_q == 5'h18)
		else $error("frame pulse count wrong");
	a_frame_len: assert property ($fell(csb) |-> ##96 !csb ##1 csb)
		else $error("frame length wrong");
	a_sclk_idle: assert property (csb |-> !sclk)
		else $error("serial clock moved outside frame");
	a_no_clash: assert property (!(sdio_h_oe && sdio_d_oe))
		else $error("both ends drive the data wire");
	a_first_drive: assert property ($fell(csb) |-> sdio_h_oe)
		else $error("host not driving at frame start");
	a_data_stable: assert property (sclk && !csb |-> $stable(sdio))
		else $error("data changed while clock high");
	a_high_phase: assert property ($rose(sclk) |=> sclk ##1 !sclk)
		else $error("clock high phase wrong");
	a_dev_window: assert property (sdio_d_oe |-> rise_q >= 5'h10 || csb)
		else $error("device drove before data phase");
	a_dev_quiet: assert property (csb && $past(csb) |-> !sdio_d_oe)
		else $error("device drives between frames");

	c_frame_start: cover property ($fell(csb));
	c_read_data: cover property ($rose(sdio_d_oe));
	c_frame_end: cover property ($rose(csb));
endmodule : asrb_props

// ### asrb_test.sv
// Testbench joining host and device ends with a reference model.
`timescale 1ns/1ns
module adc_spi_register_bank_test;
	logic		clk_sys = 1'b0;
	logic		reset = 1'b1;
	logic [7:0]	reg_addr = 8'h00;
	logic [31:0]	reg_wdata = 32'h0;
	logic		reg_wr = 1'b0;
	logic		reg_rd = 1'b0;
	logic [31:0]	reg_rdata;
	logic [6:0]	act_sel = 7'h00;
	logic [7:0]	act_a_q;
	logic [7:0]	act_b_q;
	logic		lsb_first_q;
	logic		xfer_pulse_q;
	logic [31:0]	r;
	int		failures = 0;
	int		cmp_count = 0;
	int		pulses = 0;
	int		sh[2][128];
	int		ac[2][128];
	int		chan_m;
	int		lsb_m;
	int		p;
	int unsigned	seed = 25814;
	int		ra[] = '{0, 1, 2, 5, 3, 255, 8, 9};

	asrb_link_if link ();
	asrb_host asrb_host_i (.clk_sys(clk_sys), .reset(reset),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .link(link));
	// The identity value is arbitrary.
	asrb_device #(.DEVICE_IDENTIFIER(8'h3c), .GRADE(2'h1)) asrb_device_i (
		.clk_sys(clk_sys), .reset(reset), .link(link),
		.act_sel(act_sel), .act_a_q(act_a_q), .act_b_q(act_b_q),
		.lsb_first_q(lsb_first_q), .xfer_pulse_q(xfer_pulse_q));
	asrb_props asrb_props_i (.clk_sys(clk_sys), .reset(reset),
		.sclk(link.sclk), .csb(link.csb), .sdio_h_o(link.sdio_h_o),
		.sdio_h_oe(link.sdio_h_oe), .sdio_d_o(link.sdio_d_o),
		.sdio_d_oe(link.sdio_d_oe), .sdio(link.sdio));

	always #25 clk_sys = ~clk_sys;
	always @(posedge clk_sys)
		if (xfer_pulse_q === 1'b1)
			pulses++;

	function automatic int rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : rnd

	function automatic void dflt();
		sh = '{default: 0};
		sh[0][1] = 1;
		sh[1][1] = 1;
		ac = sh;
		chan_m = 3;
		lsb_m = 0;
	endfunction : dflt

	function automatic int exp_rd(input int a);
		if (a == 0)
			return lsb_m ? 8'h5a : 8'h18;
		if (a == 1)
			return 8'h3c;
		if (a == 2)
			return 8'h10;
		if (a == 5)
			return chan_m;
		if (a >= 8 && a < 122)
			return sh[chan_m % 2 ? 0 : 1][a - 8];
		return 0;
	endfunction : exp_rd

	task automatic chk(input logic [31:0] got, input int exp);
		cmp_count++;
		if (got !== 32'(exp))
		begin
			failures++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic bw(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk_sys);
		reg_wr <= 1'b0;
	endtask : bw

	task automatic br(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk_sys);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk_sys);
		reg_rd <= 1'b0;
		@(negedge clk_sys);
		v = reg_rdata;
	endtask : br

	// Runs one serial frame and polls until the host reports it done.
	task automatic xf(input logic rw, input int a, input int v);
		int n;
		n = 0;
		bw(8'h00, 32'(a));
		bw(8'h04, 32'(v));
		bw(8'h08, {29'h0, 1'(lsb_m), rw, ~rw});
		r = 32'h0;
		while (r[1] !== 1'b1 && n < 200)
		begin
			br(8'h0c, r);
			n++;
		end
		chk(r[1], 1);
		br(8'h10, r);
	endtask : xf

	task automatic wr(input int a, input int v);
		xf(1'b0, a, v);
		if (a >= 8 && a < 122)
			for (int c = 0; c < 2; c++)
				if (a != 8 || chan_m[c])
					sh[c][a - 8] = v;
		if (a == 5)
			chan_m = v;
		if (a == 255)
			ac = sh;
		if (a == 0)
			lsb_m = (v & 8'h42) != 0;
		if (a == 0 && (v & 8'h24) != 0)
			dflt();
	endtask : wr

	task automatic rd(input int a);
		xf(1'b1, a, 0);
		chk(r[7:0], exp_rd(a));
	endtask : rd

	task automatic act_chk();
		for (int i = 0; i < 114; i++)
		begin
			@(posedge clk_sys);
			act_sel <= 7'(i);
			@(posedge clk_sys);
			@(negedge clk_sys);
			chk(act_a_q, ac[0][i]);
			chk(act_b_q, ac[1][i]);
		end
	endtask : act_chk

	task automatic results();
		if (failures == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : results

	initial
	begin
		#2000000;
		failures++;
		results();
	end

	initial
	begin
		dflt();
		repeat (3) @(posedge clk_sys);
		reset <= 1'b0;
		foreach (ra[i]) rd(ra[i]);
		act_chk();
		br(8'h14, r);
		chk(r, 0);
		repeat (6) wr(11, rnd() & 63);
		wr(9, 0);
		rd(11);
		act_chk();
		p = pulses;
		wr(255, 1);
		chk(32'(pulses - p), 1);
		rd(255);
		act_chk();
		wr(5, 1);
		wr(8, 8'h21);
		wr(5, 2);
		wr(8, 8'h02);
		wr(11, 8'h15);
		rd(8);
		wr(5, 1);
		rd(11);
		rd(8);
		wr(5, 3);
		rd(8);
		wr(8, 8'h23);
		wr(255, 1);
		act_chk();
		wr(0, 8'h5a);
		rd(0);
		rd(5);
		chk(lsb_first_q, 1);
		br(8'h08, r);
		chk(r[2], 1);
		wr(0, 8'h3c);
		rd(0);
		chk(lsb_first_q, 0);
		act_chk();
		results();
	end
endmodule : adc_spi_register_bank_test
